// >>> rtl/crs_pkg.sv
// constants and carrier types of the chip reset and power sequencer
package crs_pkg;
  localparam int CLK_KHZ     = 40000;                  // core clock in kHz
  localparam int POR_MS      = 20;                     // internal reset hold, ms
  localparam int PHY_RST_MS  = 2;                      // phy reset pulse, ms
  localparam int PHY_RDY_MS  = 125;                    // extra phy ready wait, ms
  localparam int POR_CYC     = POR_MS * CLK_KHZ;
  localparam int PHY_RST_CYC = PHY_RST_MS * CLK_KHZ;
  localparam int PHY_RDY_CYC = PHY_RDY_MS * CLK_KHZ;
  localparam int FRST_CYC    = 16;                     // function reset length
  localparam int CNT_W       = 23;                     // long timer width
  localparam int OTP_BYTES   = 128;                    // 1k bits as bytes
  // register offsets
  localparam logic [7:0] HARDWARE_CONFIG_REGISTER_OFS  = 8'h00;
  localparam logic [7:0] POWER_MGMT_CONTROL_REGISTER_OFS = 8'h04;
  localparam logic [7:0] PMCSR_OFS   = 8'h08;
  localparam logic [7:0] DEVCTL_OFS  = 8'h0c;
  localparam logic [7:0] OTP_CMD_OFS = 8'h10;
  localparam logic [7:0] OTP_DAT_OFS = 8'h14;
  // field positions
  localparam int HW_FULL_SOFT_RESET_BIT_B   = 0;
  localparam int HW_FUNCTION_ONLY_RESET_BIT_B   = 1;
  localparam int HW_STRAP_B  = 8;
  localparam int PMT_RDY_B   = 0;
  localparam int PMT_PRST_B  = 1;
  localparam int PMT_DLY_B   = 2;
  localparam int PMT_DST_B   = 4;
  localparam int PMT_D3C_B   = 6;
  localparam int CSR_NSR_B   = 3;
  localparam int DEV_FLR_B   = 15;
  localparam int DEV_PH_B    = 16;
  localparam int OTP_RD_B    = 12;
  localparam int OTP_PG_B    = 13;
  localparam int OTP_SBE_B   = 14;
  localparam int OTP_RDY_B   = 16;
  localparam int OTP_SBY_B   = 17;
  // power state codes
  localparam logic [1:0] PS_D0    = 2'h0;
  localparam logic [1:0] PS_D3HOT = 2'h3;
  // one request or completion seen on the link
  typedef struct packed {
    logic valid;   // tlp present this cycle
    logic cpl;     // completion, else request
    logic early;   // arrived before the current reset began
  } crs_tlp_in_type;
  // disposition of that tlp
  typedef struct packed {
    logic pass;    // forward normally
    logic drop;    // drop silently
    logic ur;      // answer unsupported request
    logic uc;      // discard as unexpected completion
  } crs_tlp_res_type;
endpackage : crs_pkg

// >>> rtl/crs_sequencer.sv
// chip reset, phy reset, function reset, power state and otp sequencer
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer import crs_pkg::*; #(
  parameter int   POR_CNT = POR_CYC,       // reset hold cycles
  parameter int   PRS_CNT = PHY_RST_CYC,   // phy reset cycles
  parameter int   PRD_CNT = PHY_RDY_CYC,   // phy ready wait cycles
  parameter logic EXT_PHY = 1'b1           // external phy variant
) (
  input  wire logic            CORE_CLK_I,
  input  wire logic            RSTN_I,
  input  wire logic            PSEL_I,
  input  wire logic            PENABLE_I,
  input  wire logic            PWRITE_I,
  input  wire logic [7:0]      PADDR_I,
  input  wire logic [31:0]     PWDATA_I,
  output logic      [31:0]     PRDATA_O,
  output logic                 PREADY_O,
  output logic                 PSLVERR_O,
  input  wire logic            EXT_RSTN_I,
  input  wire logic            PERSTN_I,
  input  wire logic            AUX_PWR_DET_I,
  input  wire logic [3:0]      STRAP_I,
  input  wire logic            INT_PHY_UP_I,
  input  wire logic            HOT_RST_I,
  input  wire logic            NVM_DONE_I,
  input  wire logic            INTX_ACTIVE_I,
  input  wire crs_tlp_in_type  TLP_I,
  output crs_tlp_res_type      TLP_O,
  output logic                 DEASSERT_INTX_O,
  output logic                 CHIP_RST_O,
  output logic                 NVM_LOAD_O,
  output logic                 RESTORE_O,
  output logic                 LINK_DETACH_O,
  output logic                 FUNC_RST_O,
  output logic                 PHY_RST_O,
  output logic                 EXT_PHY_RSTN_O,
  output logic                 D3COLD_O,
  output logic                 L1_REQ_O,
  output logic                 OTP_IRQ_O,
  output logic [3:0]           STRAP_O
);
  typedef enum logic [1:0] {CH_HOLD, CH_LOAD, CH_RUN} crs_chip_type;
  typedef enum logic [2:0] {S_POR, S_PIN, S_PERST, S_HOT, S_SOFT} crs_src_type;
  typedef enum logic [1:0] {PH_RST, PH_DLY, PH_UP, PH_RDY} crs_phy_type;
  typedef enum logic [1:0] {FL_IDLE, FL_START, FL_PROC, FL_EXIT} crs_flr_type;

  // pin synchronisers: first stage read only by second
  logic [7:0]       sy1_r;                 // first stage
  logic [7:0]       sy2_r;                 // second stage
  logic             perst_d_r;             // delayed perst for edge
  always_ff @(posedge CORE_CLK_I) begin
    sy1_r     <= {INT_PHY_UP_I, AUX_PWR_DET_I, PERSTN_I, EXT_RSTN_I, STRAP_I};
    sy2_r     <= sy1_r;
    perst_d_r <= sy2_r[5];
  end
  wire        ext_low    = ~sy2_r[4];      // reset pin held low
  wire        perst_n    = sy2_r[5];
  wire        aux_det    = sy2_r[6];
  wire        phy_up     = sy2_r[7];
  wire        perst_rise = perst_n & ~perst_d_r;

  // apb slave: one wait state, answer with pready
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [31:0] rdata;                      // read mux
  wire  acc    = PSEL_I & PENABLE_I;
  wire  setup  = acc & ~pready_r;          // first access cycle
  wire  done   = acc & pready_r;           // completing edge
  wire  sel_hw = PADDR_I == HARDWARE_CONFIG_REGISTER_OFS;
  wire  sel_pm = PADDR_I == POWER_MGMT_CONTROL_REGISTER_OFS;
  wire  sel_cs = PADDR_I == PMCSR_OFS;
  wire  sel_dv = PADDR_I == DEVCTL_OFS;
  wire  sel_oc = PADDR_I == OTP_CMD_OFS;
  wire  sel_od = PADDR_I == OTP_DAT_OFS;
  wire  mapped = sel_hw | sel_pm | sel_cs | sel_dv | sel_oc | sel_od;
  wire  wr     = done & PWRITE_I;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      prdata_r  <= (setup & ~PWRITE_I) ? rdata : 32'h0;
      pslverr_r <= setup & ~mapped;        // unmapped: error, data zero
    end
  end

  // chip-level reset merge
  crs_chip_type ch_r, ch_nxt;
  crs_src_type  src_r, src_nxt;
  logic [CNT_W-1:0] ccnt_r;                // hold timer
  logic [3:0]       strap_r;               // straps caught at hold exit
  wire  full_soft_reset_bit_wr  = wr & sel_hw & PWDATA_I[HW_FULL_SOFT_RESET_BIT_B];
  wire  trig     = ext_low | perst_rise | HOT_RST_I | full_soft_reset_bit_wr;
  wire  hold_end = (ch_r == CH_HOLD) & (ccnt_r == '0) & ~ext_low;
  // pin reload only where the reload strap is set
  wire  need_ld  = (src_r != S_HOT) & ((src_r != S_PIN) | sy2_r[0]);
  wire  in_rst   = ~RSTN_I | (ch_r == CH_HOLD); // clears software state
  always_comb begin
    ch_nxt  = ch_r;
    src_nxt = src_r;
    if (trig) begin
      ch_nxt = CH_HOLD;
      if (ext_low) src_nxt = S_PIN;
      else if (perst_rise) src_nxt = S_PERST;
      else if (HOT_RST_I) src_nxt = S_HOT;
      else src_nxt = S_SOFT;
    end else begin
      case (ch_r)
        CH_HOLD: if (hold_end) ch_nxt = need_ld ? CH_LOAD : CH_RUN;
        CH_LOAD: if (NVM_DONE_I) ch_nxt = CH_RUN;
        CH_RUN:  ch_nxt = CH_RUN;
        default: ch_nxt = CH_HOLD;
      endcase
    end
  end
  // hold timer restarts on every trigger, so a held pin extends it
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      ch_r   <= CH_HOLD;
      src_r  <= S_POR;
      ccnt_r <= CNT_W'(POR_CNT - 1);
    end else begin
      ch_r   <= ch_nxt;
      src_r  <= src_nxt;
      ccnt_r <= trig ? CNT_W'(POR_CNT - 1) : (ccnt_r != '0 ? ccnt_r - 1'b1 : ccnt_r);
    end
  end
  // straps caught by a clocked process after reset, never by reset
  always_ff @(posedge CORE_CLK_I) begin
    if (hold_end & ~trig) strap_r <= sy2_r[3:0];
  end

  // chip outputs
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      CHIP_RST_O    <= 1'b1;
      NVM_LOAD_O    <= 1'b0;
      LINK_DETACH_O <= 1'b0;
      STRAP_O       <= 4'h0;
    end else begin
      CHIP_RST_O    <= ch_nxt != CH_RUN;
      NVM_LOAD_O    <= ch_nxt == CH_LOAD;
      LINK_DETACH_O <= (ch_nxt == CH_HOLD) & (src_nxt == S_SOFT);
      STRAP_O       <= strap_r;
    end
  end

  // software registers
  logic       dly_en_r;                    // phy ready delay enable
  logic [1:0] dst_r;                       // function power state
  logic       nsr_r;                       // no soft reset
  logic       function_only_reset_bit_r;                      // soft-lite busy bit
  logic       d3c_r;                       // d3cold
  logic [4:0] fcnt_r;                      // function reset timer
  crs_flr_type fl_r;
  wire  function_only_reset_bit_wr = wr & sel_hw & PWDATA_I[HW_FUNCTION_ONLY_RESET_BIT_B] & ~function_only_reset_bit_r;
  wire  pm_full_soft_reset_bit = wr & sel_cs & (PWDATA_I[1:0] == PS_D0)
                  & (dst_r == PS_D3HOT) & ~nsr_r;
  wire  flr_wr  = wr & sel_dv & PWDATA_I[DEV_FLR_B] & (fl_r == FL_IDLE);
  wire  f_load  = function_only_reset_bit_wr | pm_full_soft_reset_bit | (fl_r == FL_START);
  wire  ps_ok   = (PWDATA_I[1:0] == PS_D0) | (PWDATA_I[1:0] == PS_D3HOT);
  always_ff @(posedge CORE_CLK_I) begin
    if (in_rst) begin
      dly_en_r <= 1'b0;
      dst_r    <= PS_D0;
      nsr_r    <= 1'b0;
      function_only_reset_bit_r   <= 1'b0;
      fcnt_r   <= 5'h0;
    end else begin
      if (wr & sel_pm) dly_en_r <= PWDATA_I[PMT_DLY_B];
      if (wr & sel_cs) nsr_r <= PWDATA_I[CSR_NSR_B];
      // d1/d2 unsupported: such writes keep the state
      if (wr & sel_cs & ps_ok) dst_r <= PWDATA_I[1:0];
      else if (fl_r == FL_EXIT) dst_r <= PS_D0; // d0 uninitialised
      if (function_only_reset_bit_wr) function_only_reset_bit_r <= 1'b1;
      else if (fcnt_r == 5'h1) function_only_reset_bit_r <= 1'b0;
      fcnt_r <= f_load ? 5'(FRST_CYC) : (fcnt_r != 5'h0 ? fcnt_r - 5'h1 : fcnt_r);
    end
  end

  // warm reset: aux present while perst held gives d3cold
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) d3c_r <= 1'b0;
    else if (perst_n) d3c_r <= 1'b0;
    else if (aux_det) d3c_r <= 1'b1;
  end

  // flr phases; link logic is never reset from here
  always_ff @(posedge CORE_CLK_I) begin
    if (in_rst) fl_r <= FL_IDLE;
    else begin
      case (fl_r)
        FL_IDLE:  if (flr_wr) fl_r <= FL_START;
        FL_START: fl_r <= FL_PROC;
        FL_PROC:  if (fcnt_r == 5'h1) fl_r <= FL_EXIT;
        FL_EXIT:  fl_r <= FL_IDLE;
        default:  fl_r <= FL_IDLE;
      endcase
    end
  end
  wire flr_on = fl_r != FL_IDLE;

  // function-level outputs and tlp disposition
  always_ff @(posedge CORE_CLK_I) begin
    if (in_rst) begin
      FUNC_RST_O      <= 1'b0;
      RESTORE_O       <= 1'b0;
      DEASSERT_INTX_O <= 1'b0;
      TLP_O           <= '0;
      D3COLD_O        <= 1'b0;
      L1_REQ_O        <= 1'b0;
    end else begin
      FUNC_RST_O      <= f_load | (fcnt_r > 5'h1);
      RESTORE_O       <= function_only_reset_bit_wr;
      DEASSERT_INTX_O <= (fl_r == FL_START) & INTX_ACTIVE_I;
      TLP_O.pass      <= TLP_I.valid & ~flr_on;
      TLP_O.drop      <= TLP_I.valid & flr_on & TLP_I.early;
      TLP_O.ur        <= TLP_I.valid & flr_on & ~TLP_I.early & ~TLP_I.cpl;
      TLP_O.uc        <= TLP_I.valid & flr_on & ~TLP_I.early & TLP_I.cpl;
      D3COLD_O        <= d3c_r;
      L1_REQ_O        <= (dst_r != PS_D0) | d3c_r;
    end
  end

  // phy reset and ready sequencing, separate from chip reset
  crs_phy_type      ph_r;
  logic [CNT_W-1:0] pcnt_r;
  wire prst_wr = wr & sel_pm & PWDATA_I[PMT_PRST_B];
  wire p_zero  = pcnt_r == '0;
  always_ff @(posedge CORE_CLK_I) begin
    if (in_rst | prst_wr) begin
      ph_r   <= PH_RST;
      pcnt_r <= CNT_W'(PRS_CNT - 1);
    end else begin
      pcnt_r <= p_zero ? pcnt_r : pcnt_r - 1'b1;
      case (ph_r)
        PH_RST: if (p_zero) begin
          if (!EXT_PHY) ph_r <= PH_UP;
          else if (dly_en_r) begin
            ph_r   <= PH_DLY;
            pcnt_r <= CNT_W'(PRD_CNT - 1);
          end else ph_r <= PH_RDY;
        end
        PH_DLY:  if (p_zero) ph_r <= PH_RDY;
        PH_UP:   if (phy_up) ph_r <= PH_RDY;
        PH_RDY:  ph_r <= PH_RDY;
        default: ph_r <= PH_RST;
      endcase
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      PHY_RST_O      <= 1'b1;
      EXT_PHY_RSTN_O <= 1'b0;
    end else begin
      PHY_RST_O      <= ph_r == PH_RST;
      EXT_PHY_RSTN_O <= ~EXT_PHY | (ph_r != PH_RST);
    end
  end
  wire dev_ready = (ph_r == PH_RDY) & (ch_r == CH_RUN);

  // otp: bit programming, byte reads, ready flag, standby
  logic [7:0] otp_mem_r [OTP_BYTES];       // cleared at power-on only, so blank cells read 0
  logic [9:0] oadr_r;                      // bit address
  logic [7:0] odat_r;                      // last byte read
  logic       osbe_r;                      // standby after op enable
  logic       ordy_r;                      // ready flag, write 1 to clear
  logic       osby_r;                      // in standby
  logic       oop_r;                       // op running
  logic       opg_r;                       // op is program
  wire  ocmd    = wr & sel_oc;
  wire  ostart  = ocmd & (PWDATA_I[OTP_RD_B] | PWDATA_I[OTP_PG_B]) & ~oop_r;
  wire  rdy_clr = ocmd & PWDATA_I[OTP_RDY_B];
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) otp_mem_r <= '{default: 8'h0}; // chip-level resets keep the contents
    else if (oop_r & opg_r) otp_mem_r[oadr_r[9:3]][oadr_r[2:0]] <= 1'b1;
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (in_rst) begin
      oadr_r <= 10'h0;
      odat_r <= 8'h0;
      osbe_r <= 1'b0;
      ordy_r <= 1'b0;
      osby_r <= 1'b0;
      oop_r  <= 1'b0;
      opg_r  <= 1'b0;
    end else begin
      if (ocmd) osbe_r <= PWDATA_I[OTP_SBE_B];
      if (ostart) begin
        oadr_r <= PWDATA_I[9:0];
        opg_r  <= PWDATA_I[OTP_PG_B];
        osby_r <= 1'b0;                    // wake for the op
      end
      oop_r <= ostart;
      if (oop_r & ~opg_r) odat_r <= otp_mem_r[oadr_r[9:3]];
      if (oop_r) osby_r <= osbe_r;
      // a finishing op wins over a clear in the same cycle
      if (oop_r) ordy_r <= 1'b1;
      else if (rdy_clr) ordy_r <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (in_rst) OTP_IRQ_O <= 1'b0;
    else OTP_IRQ_O <= ordy_r;
  end

  // read data mux
  assign rdata = sel_hw ? 32'({strap_r, 6'h0, function_only_reset_bit_r, 1'b0}) :
                 sel_pm ? 32'({d3c_r, dst_r, 1'b0, dly_en_r, 1'b0, dev_ready}) :
                 sel_cs ? 32'({nsr_r, 1'b0, dst_r}) :
                 sel_dv ? 32'({fl_r, 16'h0}) :
                 sel_oc ? 32'({osby_r, ordy_r, 1'b0, osbe_r, 4'h0, oadr_r}) :
                 sel_od ? 32'(odat_r) : 32'h0;
  assign PRDATA_O  = prdata_r;
  assign PREADY_O  = pready_r;
  assign PSLVERR_O = pslverr_r;

  // checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  hold_exit_a: assert property (hold_end & ~trig |=> ch_r != CH_HOLD)
    else $error("hold did not end at zero count");
  pin_reset_a: assert property (ext_low |=> ch_r == CH_HOLD ##1 CHIP_RST_O)
    else $error("reset pin did not reset chip");
  perst_rel_a: assert property (perst_rise |=> ch_r == CH_HOLD && src_r == S_PERST)
    else $error("perst release did not reset");
  perst_lvl_a: assert property (ch_r == CH_RUN && !trig |=> ch_r == CH_RUN)
    else $error("reset without release edge");
  warm_d3c_a: assert property (aux_det && !perst_n |=> ##1 D3COLD_O)
    else $error("warm reset missed d3cold");
  flr_intx_a: assert property (fl_r == FL_START && INTX_ACTIVE_I |=> DEASSERT_INTX_O)
    else $error("intx deassert missing");
  flr_drop_a: assert property (flr_on && TLP_I.valid && TLP_I.early |=> TLP_O.drop && !TLP_O.pass)
    else $error("early tlp not dropped");
  flr_ur_a: assert property (flr_on && TLP_I.valid && !TLP_I.early |=> TLP_O.ur != TLP_O.uc)
    else $error("late tlp not refused");
  lite_clear_a: assert property ($rose(function_only_reset_bit_r) |-> ##[16:17] !function_only_reset_bit_r)
    else $error("soft-lite bit did not self-clear");
  pm_reset_a: assert property (pm_full_soft_reset_bit && !in_rst |=> FUNC_RST_O && dst_r == PS_D0)
    else $error("pm soft reset missing");
  phy_pin_a: assert property (ph_r == PH_RST |=> !EXT_PHY_RSTN_O || !EXT_PHY)
    else $error("phy pin not asserted");
  l1_entry_a: assert property (dst_r == PS_D3HOT && !in_rst |=> L1_REQ_O)
    else $error("l1 not requested");
  flr_done_c: cover property (fl_r == FL_EXIT);
  lite_done_c: cover property ($fell(function_only_reset_bit_r));
  otp_read_c: cover property (oop_r && !opg_r);
  phy_dly_c: cover property (ph_r == PH_DLY ##1 ph_r == PH_RDY);
endmodule : crs_sequencer
`default_nettype wire

// >>> verif/crs_link_model.sv
// link-side partner: sends tlps and plays the configuration loader
`timescale 1ns/1ps
`default_nettype none
module crs_link_model import crs_pkg::*; (
  input  wire logic       clk_i,    // core clock
  input  wire logic       go_i,     // put one tlp on the link next edge
  input  wire logic       cpl_i,    // completion, else request
  input  wire logic       early_i,  // tlp arrived before the reset began
  input  wire logic [3:0] dly_i,    // loader latency in cycles
  input  wire logic       load_i,   // load requested by the sequencer
  output crs_tlp_in_type  tlp_o,    // tlp towards the sequencer
  output logic            done_o    // loader finished
);
  logic [3:0] cnt_r;  // cycles spent in the current load
  initial begin
    tlp_o  = '0;
    cnt_r  = 4'h0;
    done_o = 1'h0;
  end
  // one tlp per request; idle fields flip so nothing leans on stale values
  always @(posedge clk_i) begin
    if (go_i) begin
      tlp_o <= '{valid: 1'h1, cpl: cpl_i, early: early_i};
    end else begin
      tlp_o <= '{valid: 1'h0, cpl: ~tlp_o.cpl, early: ~tlp_o.early};
    end
  end
  // loader answers dly cycles into a load and lets go once the load ends
  always @(posedge clk_i) begin
    cnt_r  <= load_i ? cnt_r + 4'h1 : 4'h0;
    done_o <= load_i && (cnt_r >= dly_i);
  end
endmodule : crs_link_model
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench of the chip reset and power sequencer
`timescale 1ns/1ps
`default_nettype none
module tb import crs_pkg::*; ;
  localparam int POR = 40;  // shortened hold
  localparam int PRS = 20;  // shortened phy pulse
  localparam int PRD = 30;  // shortened phy ready wait
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d, ex, m; logic er;} crs_row_type;
  logic            clk, rstn, psel, pen, pwr, pready, pslverr, ext_rstn, perstn, aux, hot, nvm_done, intx;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, prdata_int, q;
  logic [3:0]      strap, strap_o, dly;
  logic            deas, chip, nvm, rest, det, fr, phy, ephy_n, d3c, l1, irq, go, gcpl, gearly, e, phy_up;
  crs_tlp_in_type  tlp_i;
  crs_tlp_res_type tlp_o;
  int              n_errors, n_checks, cyc, n;
  // four-state counters: an unknown output spoils the count instead of reading as zero
  integer          c_func, c_phy, c_epin, c_nvm, c_det, c_rest, c_deas, c_chip, c_irq;
  // register table: reads hold expected data under a mask, writes only the error
  crs_row_type rows [15] = '{
    '{1'h0, 8'h00, 32'h0, 32'h00000a00, 32'hffffffff, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h1, 32'hffffffff, 1'h0},
    '{1'h1, 8'h04, 32'h4, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h5, 32'hffffffff, 1'h0},
    '{1'h1, 8'h04, 32'h0, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h08, 32'h0, 32'h0, 32'hffffffff, 1'h0},
    '{1'h0, 8'h0c, 32'h0, 32'h0, 32'hffffffff, 1'h0}, '{1'h1, 8'h10, 32'h201b, 32'h0, 32'h0, 1'h0},
    '{1'h1, 8'h10, 32'h5018, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h14, 32'h0, 32'h08, 32'hff, 1'h0},
    '{1'h0, 8'h10, 32'h0, 32'h30000, 32'h30000, 1'h0}, '{1'h1, 8'h10, 32'h10000, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h10, 32'h0, 32'h0, 32'h10000, 1'h0}, '{1'h1, 8'h20, 32'h1, 32'h0, 32'h0, 1'h1},
    '{1'h0, 8'h20, 32'h0, 32'h0, 32'hffffffff, 1'h1}};
  crs_sequencer #(.POR_CNT(POR), .PRS_CNT(PRS), .PRD_CNT(PRD), .EXT_PHY(1'h1)) i_dut (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_RSTN_I(ext_rstn),
    .PERSTN_I(perstn), .AUX_PWR_DET_I(aux), .STRAP_I(strap), .INT_PHY_UP_I(1'h0), .HOT_RST_I(hot),
    .NVM_DONE_I(nvm_done), .INTX_ACTIVE_I(intx), .TLP_I(tlp_i), .TLP_O(tlp_o), .DEASSERT_INTX_O(deas),
    .CHIP_RST_O(chip), .NVM_LOAD_O(nvm), .RESTORE_O(rest), .LINK_DETACH_O(det), .FUNC_RST_O(fr),
    .PHY_RST_O(phy), .EXT_PHY_RSTN_O(ephy_n), .D3COLD_O(d3c), .L1_REQ_O(l1), .OTP_IRQ_O(irq), .STRAP_O(strap_o));
  crs_link_model i_link (.clk_i(clk), .go_i(go), .cpl_i(gcpl), .early_i(gearly), .dly_i(dly), .load_i(nvm),
    .tlp_o(tlp_i), .done_o(nvm_done));
  // internal-phy variant on the same bus and pins; only its ready path is examined
  crs_sequencer #(.POR_CNT(POR), .PRS_CNT(PRS), .PRD_CNT(PRD), .EXT_PHY(1'h0)) i_dut_int (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata_int), .PREADY_O(), .PSLVERR_O(), .EXT_RSTN_I(ext_rstn),
    .PERSTN_I(perstn), .AUX_PWR_DET_I(aux), .STRAP_I(strap), .INT_PHY_UP_I(phy_up), .HOT_RST_I(hot),
    .NVM_DONE_I(nvm_done), .INTX_ACTIVE_I(intx), .TLP_I(tlp_i), .TLP_O(), .DEASSERT_INTX_O(),
    .CHIP_RST_O(), .NVM_LOAD_O(), .RESTORE_O(), .LINK_DETACH_O(), .FUNC_RST_O(),
    .PHY_RST_O(), .EXT_PHY_RSTN_O(), .D3COLD_O(), .L1_REQ_O(), .OTP_IRQ_O(), .STRAP_O());
  // clock of 25 ns
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // event counters and the hang guard; a test reads them after clr
  always @(posedge clk) begin
    cyc++;
    c_func += fr; c_phy += phy; c_epin += !ephy_n; c_nvm += nvm; c_det += det;
    c_rest += rest; c_deas += deas; c_chip += chip; c_irq += irq;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  // counters cleared off the edge so the monitor never races the clear
  task automatic clr();
    #1;
    {c_func, c_phy, c_epin, c_nvm, c_det, c_rest, c_deas, c_chip, c_irq} = '0;
  endtask : clr
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge clk); psel <= 1'h1; pen <= 1'h0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk); pen <= 1'h1;
    // no cycle limit here: only the bench timeout ends a wait for pready
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb
  // one tlp through the partner; result stands one cycle after it
  task automatic send_tlp(input logic c, input logic ea, input logic [3:0] ex);
    @(posedge clk); go <= 1'h1; gcpl <= c; gearly <= ea;
    @(posedge clk); go <= 1'h0;
    @(posedge clk); #1;
    chk("tlp_res", ex, tlp_o);
  endtask : send_tlp
  // waits for a chip hold to start and end, then for the phy pulse
  task automatic wait_chip();
    int k;
    for (k = 0; k < 20 && chip !== 1'h1; k++) @(posedge clk);
    chk("chip_rise", 1, chip);
    for (k = 0; k < 400 && chip !== 1'h0; k++) @(posedge clk);
    chk("chip_fall", 0, chip);
    repeat (PRS + 10) @(posedge clk);
  endtask : wait_chip
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    n_errors = 0; n_checks = 0; cyc = 0; rstn = 1'h0; psel = 1'h0; pen = 1'h0; pwr = 1'h0;
    paddr = 8'h0; pwdata = 32'h0; ext_rstn = 1'h1; perstn = 1'h1; aux = 1'h0; hot = 1'h0;
    strap = 4'ha; intx = 1'h0; go = 1'h0; gcpl = 1'h0; gearly = 1'h0; dly = 4'h3; phy_up = 1'h0;
    repeat (10) @(posedge clk);
    chk("rst_chip", 1, chip);
    chk("rst_pin", 0, ephy_n);
    rstn <= 1'h1;
    clr();
    for (n = 0; n < POR + 20 && nvm !== 1'h1; n++) @(posedge clk);
    chk("hold_len", 1, n >= POR && n <= POR + 6);
    wait_chip();
    chk("strap_take", 4'ha, strap_o);
    // internal phy: ready waits for the phy to report itself functional
    apb(1'h0, POWER_MGMT_CONTROL_REGISTER_OFS, 32'h0, q, e);
    chk("int_rdy_wait", 0, prdata_int[0]);
    phy_up <= 1'h1;
    repeat (4) @(posedge clk);
    apb(1'h0, POWER_MGMT_CONTROL_REGISTER_OFS, 32'h0, q, e);
    chk("int_rdy_up", 1, prdata_int[0]);
    $display("test reset done");
    // ordinary register accesses from the table
    clr();
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d, q, e);
      chk("row_err", rows[i].er, e);
      if (!rows[i].wr) chk("row_data", rows[i].ex, q & rows[i].m);
    end
    chk("otp_irq", 1, c_irq > 0);
    $display("test table done");
    // function reset with intx outstanding; a request from before it is dropped
    clr();
    intx <= 1'h1;
    apb(1'h1, DEVCTL_OFS, 32'h8000, q, e);
    send_tlp(1'h0, 1'h1, 4'h4);
    send_tlp(1'h0, 1'h0, 4'h2);
    send_tlp(1'h1, 1'h0, 4'h1);
    repeat (30) @(posedge clk);
    send_tlp(1'h0, 1'h0, 4'h8);
    chk("flr_len", FRST_CYC, c_func);
    chk("flr_intx", 1, c_deas);
    chk("flr_link", 0, c_chip + c_det);
    intx <= 1'h0;
    $display("test flr done");
    // soft-lite: dma and interrupts already idle, then 5 us of silence
    clr();
    apb(1'h1, HARDWARE_CONFIG_REGISTER_OFS, 32'h2, q, e);
    repeat (200) @(posedge clk);
    apb(1'h0, HARDWARE_CONFIG_REGISTER_OFS, 32'h0, q, e);
    chk("lite_clear", 32'ha00, q);
    chk("lite_restore", 1, c_rest);
    chk("lite_no_reload", 0, c_nvm + c_chip);
    $display("test softlite done");
    // power state: d3hot asks for l1, back to d0 gives pm reset unless nsr
    clr();
    apb(1'h1, PMCSR_OFS, 32'h3, q, e);
    repeat (3) @(posedge clk);
    chk("l1_on", 1, l1);
    apb(1'h1, PMCSR_OFS, 32'h0, q, e);
    repeat (20) @(posedge clk);
    chk("pm_len", FRST_CYC, c_func);
    chk("l1_off", 0, l1);
    clr();
    apb(1'h1, PMCSR_OFS, 32'hb, q, e);
    apb(1'h1, PMCSR_OFS, 32'h8, q, e);
    repeat (20) @(posedge clk);
    chk("nsr_keep", 0, c_func);
    $display("test pm done");
    // phy soft reset with the extra ready wait
    clr();
    apb(1'h1, POWER_MGMT_CONTROL_REGISTER_OFS, 32'h6, q, e);
    repeat (PRS + 5) @(posedge clk);
    apb(1'h0, POWER_MGMT_CONTROL_REGISTER_OFS, 32'h0, q, e);
    chk("rdy_wait", 32'h4, q & 32'h7);
    chk("phy_len", 1, c_phy >= PRS && c_phy <= PRS + 1);
    chk("pin_len", c_phy, c_epin);
    chk("phy_only", 0, c_chip + c_func);
    repeat (PRD) @(posedge clk);
    apb(1'h0, POWER_MGMT_CONTROL_REGISTER_OFS, 32'h0, q, e);
    chk("rdy_up", 32'h5, q & 32'h7);
    $display("test phy done");
    // chip triggers: soft, pin without and with reload, warm perst, hot
    for (int k = 0; k < 5; k++) begin
      clr();
      dly <= k[0] ? 4'h9 : 4'h1;
      if (k == 0) apb(1'h1, HARDWARE_CONFIG_REGISTER_OFS, 32'h1, q, e);
      @(posedge clk);
      case (k)
        1: ext_rstn <= 1'h0;
        2: begin
          strap <= 4'hb;
          ext_rstn <= 1'h0;
        end
        3: begin
          aux <= 1'h1;
          perstn <= 1'h0;
        end
        4: hot <= 1'h1;
        default: ;
      endcase
      repeat (8) @(posedge clk);
      if (k == 3) chk("perst_level", 0, chip);
      if (k == 3) chk("d3cold_on", 1, d3c);
      ext_rstn <= 1'h1;
      perstn <= 1'h1;
      hot <= 1'h0;
      wait_chip();
      aux <= 1'h0;
      chk("trig_nvm", k != 1 && k != 4, c_nvm > 0);
      chk("trig_detach", k == 0, c_det > 0);
      chk("d3cold_off", 0, d3c);
    end
    chk("strap_reload", 4'hb, strap_o);
    $display("test triggers done");
    close_out();
  end
endmodule : tb
`default_nettype wire
